/* File: core/ssb_sequencer.sv */
// Overview of operation
// - self-adjust load 0..2 accepted; used only when adjust mode equals four.
// - vibration select 0 off, 1 warning, 2 alarm on detection.
// - vibration sensitivity 50..500 percent of reference gain.
// - vibration base speed level 0..5000 rpm.
// - residual vibration amplitude 1..3000, 0.1 percent of completion threshold.
// - group-one stop (servo-off uses no dynamic brake): 0 brake keep, 1 brake then release, 2 coast.
// - group-two stop: 0 group-one, 1 torque decel, 2 timed decel, then group-one.
// - overtravel: 0 group-one, 1/2 torque decel, 3/4 timed; odd lock, even free.
// - extra stop selector: 0 group-one, 1 torque, 2 timed, then group-one.
// - stop torque 0..350 percent.
// - timed stop duration 0..60000 ms.
// - wait brake-release delay 0..500 ms before accepting motion commands.
// - after enable, reject position commands until static delay elapses.
// - stationary disable: engage brake, keep power for static delay, then off.
// - rotating disable: brake when speed below threshold or max wait expires.
// - rotating max wait 0..1000 ms.
// - index pulse width 0..1000 x 0.1 ms; zero picks default width.
`default_nettype none
module ssb_sequencer
    import ssb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_enable,
    input wire logic i_fault_g1,
    input wire logic i_fault_g2,
    input wire logic i_overtravel,
    input wire logic i_quick_stop,
    input wire logic [12:0] i_speed_rpm,
    input wire logic i_vib_detect,
    input wire logic i_index_event,
    output logic o_brake_engage,
    output logic o_motor_power,
    output logic o_dynamic_brake,
    output logic o_torque_decel,
    output logic o_timed_decel,
    output logic o_cmd_accept,
    output logic o_index_pulse,
    output logic o_vib_warning,
    output logic o_vib_alarm,
    output logic o_irq
);
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // pin inputs pass two flops
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic [12:0] spd1_r;
    logic [12:0] spd2_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
            spd1_r <= 13'h0000;
            spd2_r <= 13'h0000;
        end else begin
            sync1_r <= {i_enable, i_fault_g1, i_fault_g2, i_overtravel, i_quick_stop,
                        i_vib_detect, i_index_event};
            sync2_r <= sync1_r;
            spd1_r <= i_speed_rpm;
            spd2_r <= spd1_r;
        end
    end
    logic en_s, g1_s, g2_s, ot_s, qs_s, vib_s, idx_s;
    assign {en_s, g1_s, g2_s, ot_s, qs_s, vib_s, idx_s} = sync2_r;

    // settings
    logic [2:0] adj_mode_r;
    logic [1:0] load_r;
    logic [1:0] vib_sel_r;
    logic [8:0] vib_sens_r;
    logic [12:0] vib_speed_r;
    logic [11:0] resid_r;
    logic [1:0] g1_sel_r;
    logic [1:0] g2_sel_r;
    logic [2:0] ot_sel_r;
    logic [1:0] qs_sel_r;
    logic [8:0] torque_r;
    logic [15:0] decel_r;
    logic [8:0] rel_dly_r;
    logic [8:0] stat_dly_r;
    logic [12:0] rot_spd_r;
    logic [9:0] rot_wait_r;
    logic [9:0] idx_w_r;
    logic [SSB_IRQ_W-1:0] irq_stat_r;
    logic [SSB_IRQ_W-1:0] irq_mask_r;
    logic [SSB_IRQ_W-1:0] irq_set;

    logic wr_acc;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    logic [15:0] wlo;
    assign wlo = i_pwdata[15:0];

    // out-of-range writes are clamped so downstream logic never sees illegal codes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            adj_mode_r <= 3'h0;
            load_r <= 2'h0;
            vib_sel_r <= 2'h0;
            vib_sens_r <= SSB_VIB_SENS_RST;
            vib_speed_r <= 13'h0000;
            resid_r <= SSB_RESID_RST;
            g1_sel_r <= 2'h0;
            g2_sel_r <= 2'h0;
            ot_sel_r <= 3'h0;
            qs_sel_r <= 2'h0;
            torque_r <= 9'h000;
            decel_r <= 16'h0000;
            rel_dly_r <= 9'h000;
            stat_dly_r <= 9'h000;
            rot_spd_r <= 13'h0000;
            rot_wait_r <= 10'h000;
            idx_w_r <= 10'h000;
        end else if (wr_acc) begin
            if (i_paddr == SSB_ADDR_ADJUST) begin
                adj_mode_r <= 3'(clamp16({13'h0, i_pwdata[2:0]}, 16'h0,
                                         {13'h0, SSB_ADJ_MODE_MAX}));
                load_r <= 2'(clamp16({14'h0, i_pwdata[9:8]}, 16'h0,
                                     {14'h0, SSB_SEL2_MAX}));
            end else if (i_paddr == SSB_ADDR_VIB) begin
                vib_sel_r <= 2'(clamp16({14'h0, i_pwdata[1:0]}, 16'h0,
                                        {14'h0, SSB_SEL2_MAX}));
                vib_sens_r <= 9'(clamp16({7'h0, i_pwdata[12:4]}, {7'h0, SSB_VIB_SENS_MIN},
                                         {7'h0, SSB_VIB_SENS_MAX}));
                resid_r <= 12'(clamp16({4'h0, i_pwdata[27:16]}, {4'h0, SSB_RESID_MIN},
                                       {4'h0, SSB_RESID_MAX}));
            end else if (i_paddr == SSB_ADDR_VIB_LEVEL) begin
                vib_speed_r <= 13'(clamp16(wlo, 16'h0, {3'h0, SSB_VIB_SPEED_MAX}));
            end else if (i_paddr == SSB_ADDR_STOP_CFG) begin
                g1_sel_r <= 2'(clamp16({14'h0, i_pwdata[1:0]}, 16'h0, {14'h0, SSB_SEL2_MAX}));
                g2_sel_r <= 2'(clamp16({14'h0, i_pwdata[5:4]}, 16'h0, {14'h0, SSB_SEL2_MAX}));
                ot_sel_r <= 3'(clamp16({13'h0, i_pwdata[10:8]}, 16'h0, {13'h0, SSB_OT_MAX}));
                qs_sel_r <= 2'(clamp16({14'h0, i_pwdata[13:12]}, 16'h0, {14'h0, SSB_SEL2_MAX}));
            end else if (i_paddr == SSB_ADDR_STOP_TORQUE) begin
                torque_r <= 9'(clamp16(wlo, 16'h0, {7'h0, SSB_TORQUE_MAX}));
            end else if (i_paddr == SSB_ADDR_STOP_TIME) begin
                decel_r <= clamp16(wlo, 16'h0, SSB_DECEL_MAX);
            end else if (i_paddr == SSB_ADDR_BRAKE_DLY) begin
                rel_dly_r <= 9'(clamp16(wlo, 16'h0, {7'h0, SSB_BRAKE_DLY_MAX}));
                stat_dly_r <= 9'(clamp16(i_pwdata[31:16], 16'h0, {7'h0, SSB_BRAKE_DLY_MAX}));
            end else if (i_paddr == SSB_ADDR_ROT_BRAKE) begin
                rot_spd_r <= 13'(clamp16(wlo, 16'h0, {3'h0, SSB_ROT_SPEED_MAX}));
                rot_wait_r <= 10'(clamp16(i_pwdata[31:16], 16'h0,
                                          {6'h0, SSB_ROT_WAIT_MAX}));
            end else if (i_paddr == SSB_ADDR_INDEX) begin
                idx_w_r <= 10'(clamp16(wlo, 16'h0, {6'h0, SSB_INDEX_MAX}));
            end
        end
    end

    // 0.1 ms tick and 1 ms tick
    logic [14:0] pre_r;
    logic [3:0] ms_div_r;
    logic tick_r;
    logic ms_tick_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_r <= 15'h0000;
            ms_div_r <= 4'h0;
            tick_r <= 1'b0;
            ms_tick_r <= 1'b0;
        end else begin
            tick_r <= (pre_r == SSB_TICK_LAST);
            ms_tick_r <= (pre_r == SSB_TICK_LAST) && (ms_div_r == SSB_TICKS_PER_MS - 4'h1);
            if (pre_r == SSB_TICK_LAST) begin
                pre_r <= 15'h0000;
                ms_div_r <= (ms_div_r == SSB_TICKS_PER_MS - 4'h1) ? 4'h0 : ms_div_r + 4'h1;
            end else begin
                pre_r <= pre_r + 15'h0001;
            end
        end
    end

    // effective stop selection: 1 torque, 2 timed (overtravel 1/2, 3/4), 0 -> group-one method
    logic any_g2, use_torque, use_timed, lock_after;
    always_comb begin
        use_torque = 1'b0;
        use_timed = 1'b0;
        lock_after = 1'b0;
        any_g2 = 1'b0;
        if (g1_s) begin
            any_g2 = 1'b0;
        end else if (g2_s && g2_sel_r != 2'h0) begin
            any_g2 = 1'b1;
            use_torque = (g2_sel_r == 2'h1);
            use_timed = (g2_sel_r == 2'h2);
        end else if (ot_s && ot_sel_r != 3'h0) begin
            any_g2 = 1'b1;
            use_torque = (ot_sel_r == 3'h1) || (ot_sel_r == 3'h2);
            use_timed = (ot_sel_r == 3'h3) || (ot_sel_r == 3'h4);
            lock_after = ot_sel_r[0];
        end else if (qs_s && qs_sel_r != 2'h0) begin
            any_g2 = 1'b1;
            use_torque = (qs_sel_r == 2'h1);
            use_timed = (qs_sel_r == 2'h2);
        end
    end
    logic stop_req;
    assign stop_req = !en_s || g1_s || g2_s || ot_s || qs_s;

    ssb_state_t state_r;
    logic [15:0] cnt_r;
    logic lock_r;
    logic stationary;
    assign stationary = (spd2_r == 13'h0000);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= SSB_ST_OFF;
            cnt_r <= 16'h0000;
            lock_r <= 1'b0;
        end else begin
            case (state_r)
                SSB_ST_OFF: begin
                    cnt_r <= 16'h0000;
                    if (!stop_req) begin
                        state_r <= SSB_ST_RELEASE;
                    end
                end
                SSB_ST_RELEASE: begin
                    // longer of release and static delays gates commands
                    if (stop_req) begin
                        state_r <= SSB_ST_OFF;
                        cnt_r <= 16'h0000;
                    end else if (cnt_r >= {7'h0, rel_dly_r} && cnt_r >= {7'h0, stat_dly_r}) begin
                        state_r <= SSB_ST_RUN;
                    end else if (ms_tick_r) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                SSB_ST_RUN: begin
                    cnt_r <= 16'h0000;
                    lock_r <= 1'b0;
                    if (stop_req) begin
                        if (any_g2 && (use_torque || use_timed)) begin
                            state_r <= SSB_ST_DECEL;
                            lock_r <= lock_after;
                        end else if (g1_s || g2_s || ot_s || qs_s) begin
                            state_r <= SSB_ST_DB_STOP;
                        end else if (stationary) begin
                            state_r <= SSB_ST_STAT_HOLD;
                        end else begin
                            state_r <= SSB_ST_ROT_WAIT;
                        end
                    end
                end
                SSB_ST_DECEL: begin
                    if (g1_s) begin
                        state_r <= SSB_ST_DB_STOP;
                        cnt_r <= 16'h0000;
                    end else if (stationary || (use_timed && cnt_r >= decel_r)) begin
                        state_r <= lock_r ? SSB_ST_DECEL : SSB_ST_DB_STOP;
                    end else if (ms_tick_r) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                    if (lock_r && !stop_req) begin
                        state_r <= SSB_ST_RUN;
                    end
                end
                SSB_ST_ROT_WAIT: begin
                    if (spd2_r < rot_spd_r || cnt_r >= {6'h0, rot_wait_r}) begin
                        state_r <= SSB_ST_OFF;
                    end else if (ms_tick_r) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                SSB_ST_STAT_HOLD: begin
                    if (cnt_r >= {7'h0, stat_dly_r}) begin
                        state_r <= SSB_ST_OFF;
                    end else if (ms_tick_r) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                SSB_ST_DB_STOP: begin
                    cnt_r <= 16'h0000;
                    if (stationary && !stop_req) begin
                        state_r <= SSB_ST_OFF;
                    end
                end
                default: begin
                    state_r <= SSB_ST_OFF;
                end
            endcase
        end
    end

    // drive outputs from state
    logic stopped_pulse;
    assign stopped_pulse = (state_r == SSB_ST_DB_STOP || state_r == SSB_ST_DECEL) && stationary;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_brake_engage <= 1'b1;
            o_motor_power <= 1'b0;
            o_dynamic_brake <= 1'b0;
            o_torque_decel <= 1'b0;
            o_timed_decel <= 1'b0;
            o_cmd_accept <= 1'b0;
        end else begin
            o_brake_engage <= !(state_r == SSB_ST_RELEASE || state_r == SSB_ST_RUN ||
                                state_r == SSB_ST_DECEL || state_r == SSB_ST_ROT_WAIT);
            o_motor_power <= (state_r != SSB_ST_OFF) && (state_r != SSB_ST_DB_STOP);
            // dynamic brake only while stopping unless group-one says coast
            o_dynamic_brake <= (state_r == SSB_ST_DB_STOP) &&
                               (g1_sel_r != SSB_G1_COAST) &&
                               (!stationary || g1_sel_r == SSB_G1_DB_KEEP);
            o_torque_decel <= (state_r == SSB_ST_DECEL) && use_torque;
            o_timed_decel <= (state_r == SSB_ST_DECEL) && use_timed;
            o_cmd_accept <= (state_r == SSB_ST_RUN);
        end
    end

    // vibration reporting; detector itself lives upstream, scaled by these settings
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_vib_warning <= 1'b0;
            o_vib_alarm <= 1'b0;
        end else begin
            o_vib_warning <= vib_s && (vib_sel_r == 2'h1);
            o_vib_alarm <= (vib_s && (vib_sel_r == 2'h2)) || (o_vib_alarm && vib_sel_r == 2'h2);
        end
    end

    // index pulse stretcher counted in 0.1 ms ticks
    logic [9:0] idx_cnt_r;
    logic idx_d_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_cnt_r <= 10'h000;
            idx_d_r <= 1'b0;
            o_index_pulse <= 1'b0;
        end else begin
            idx_d_r <= idx_s;
            if (idx_s && !idx_d_r) begin
                idx_cnt_r <= (idx_w_r == 10'h000) ? SSB_INDEX_DEFAULT : idx_w_r;
                o_index_pulse <= 1'b1;
            end else if (idx_cnt_r == 10'h000) begin
                o_index_pulse <= 1'b0;
            end else if (tick_r) begin
                idx_cnt_r <= idx_cnt_r - 10'h001;
            end
        end
    end

    // interrupts: set wins over write-one-to-clear
    assign irq_set = {state_r == SSB_ST_OFF && o_motor_power, stopped_pulse,
                      o_vib_alarm, o_vib_warning};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr_acc && i_paddr == SSB_ADDR_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~i_pwdata[SSB_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            if (wr_acc && i_paddr == SSB_ADDR_IRQ_MASK) begin
                irq_mask_r <= i_pwdata[SSB_IRQ_W-1:0];
            end
            o_irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // apb read; no wait state, read data registered during the setup cycle
    logic acc_ok;
    logic [31:0] rd;
    always_comb begin
        acc_ok = 1'b1;
        rd = 32'h0000_0000;
        if (i_paddr == SSB_ADDR_CTRL) begin
            rd = 32'h0000_0000;
        end else if (i_paddr == SSB_ADDR_ADJUST) begin
            // load setting shown as effective only in self-adjust mode
            rd = {22'h0, (adj_mode_r == SSB_ADJ_MODE_SELF) ? load_r : 2'h0, 5'h0, adj_mode_r};
        end else if (i_paddr == SSB_ADDR_VIB) begin
            rd = {4'h0, resid_r, 3'h0, vib_sens_r, 2'h0, vib_sel_r};
        end else if (i_paddr == SSB_ADDR_VIB_LEVEL) begin
            rd = {19'h0, vib_speed_r};
        end else if (i_paddr == SSB_ADDR_STOP_CFG) begin
            rd = {18'h0, qs_sel_r, 1'b0, ot_sel_r, 2'h0, g2_sel_r, 2'h0, g1_sel_r};
        end else if (i_paddr == SSB_ADDR_STOP_TORQUE) begin
            rd = {23'h0, torque_r};
        end else if (i_paddr == SSB_ADDR_STOP_TIME) begin
            rd = {16'h0, decel_r};
        end else if (i_paddr == SSB_ADDR_BRAKE_DLY) begin
            rd = {7'h0, stat_dly_r, 7'h0, rel_dly_r};
        end else if (i_paddr == SSB_ADDR_ROT_BRAKE) begin
            rd = {6'h0, rot_wait_r, 3'h0, rot_spd_r};
        end else if (i_paddr == SSB_ADDR_INDEX) begin
            rd = {22'h0, idx_w_r};
        end else if (i_paddr == SSB_ADDR_STATUS) begin
            rd = {18'h0, 1'b0, state_r, o_cmd_accept, o_brake_engage,
                  o_motor_power, o_dynamic_brake, o_vib_warning, o_vib_alarm};
        end else if (i_paddr == SSB_ADDR_IRQ_STAT) begin
            rd = {28'h0, irq_stat_r};
        end else if (i_paddr == SSB_ADDR_IRQ_MASK) begin
            rd = {28'h0, irq_mask_r};
        end else begin
            acc_ok = 1'b0;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !acc_ok;
            o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* File: core/ssb_pkg.sv */
`default_nettype none
package ssb_pkg;
    // apb byte offsets
    localparam logic [7:0] SSB_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SSB_ADDR_ADJUST = 8'h04;
    localparam logic [7:0] SSB_ADDR_VIB = 8'h08;
    localparam logic [7:0] SSB_ADDR_VIB_LEVEL = 8'h0C;
    localparam logic [7:0] SSB_ADDR_STOP_CFG = 8'h10;
    localparam logic [7:0] SSB_ADDR_STOP_TORQUE = 8'h14;
    localparam logic [7:0] SSB_ADDR_STOP_TIME = 8'h18;
    localparam logic [7:0] SSB_ADDR_BRAKE_DLY = 8'h1C;
    localparam logic [7:0] SSB_ADDR_ROT_BRAKE = 8'h20;
    localparam logic [7:0] SSB_ADDR_INDEX = 8'h24;
    localparam logic [7:0] SSB_ADDR_STATUS = 8'h28;
    localparam logic [7:0] SSB_ADDR_IRQ_STAT = 8'h2C;
    localparam logic [7:0] SSB_ADDR_IRQ_MASK = 8'h30;
    // setting limits
    localparam logic [2:0] SSB_ADJ_MODE_MAX = 3'h4;
    localparam logic [2:0] SSB_ADJ_MODE_SELF = 3'h4;
    localparam logic [1:0] SSB_SEL2_MAX = 2'h2;
    localparam logic [2:0] SSB_OT_MAX = 3'h4;
    localparam logic [8:0] SSB_VIB_SENS_MIN = 9'h032;
    localparam logic [8:0] SSB_VIB_SENS_MAX = 9'h1F4;
    localparam logic [12:0] SSB_VIB_SPEED_MAX = 13'h1388;
    localparam logic [11:0] SSB_RESID_MIN = 12'h001;
    localparam logic [11:0] SSB_RESID_MAX = 12'hBB8;
    localparam logic [8:0] SSB_TORQUE_MAX = 9'h15E;
    localparam logic [15:0] SSB_DECEL_MAX = 16'hEA60;
    localparam logic [8:0] SSB_BRAKE_DLY_MAX = 9'h1F4;
    localparam logic [12:0] SSB_ROT_SPEED_MAX = 13'h1770;
    localparam logic [9:0] SSB_ROT_WAIT_MAX = 10'h3E8;
    localparam logic [9:0] SSB_INDEX_MAX = 10'h3E8;
    localparam logic [9:0] SSB_INDEX_DEFAULT = 10'h00A;
    // reset values
    localparam logic [8:0] SSB_VIB_SENS_RST = 9'h064;
    localparam logic [11:0] SSB_RESID_RST = 12'h001;
    // tick timing
    localparam int SSB_CLK_HZ = 200000000;
    localparam int SSB_TICK_US = 100;
    localparam int SSB_TICK_CYC = SSB_CLK_HZ / 1000000 * SSB_TICK_US;
    localparam logic [14:0] SSB_TICK_LAST = 15'(SSB_TICK_CYC - 1);
    localparam logic [3:0] SSB_TICKS_PER_MS = 4'hA;
    // stop selector codes
    localparam logic [1:0] SSB_G1_DB_KEEP = 2'h0;
    localparam logic [1:0] SSB_G1_DB_FREE = 2'h1;
    localparam logic [1:0] SSB_G1_COAST = 2'h2;
    // irq bits
    localparam int SSB_IRQ_VIB_WARN = 0;
    localparam int SSB_IRQ_VIB_ALARM = 1;
    localparam int SSB_IRQ_STOPPED = 2;
    localparam int SSB_IRQ_BRAKE = 3;
    localparam int SSB_IRQ_W = 4;
    typedef enum logic [6:0] {
        SSB_ST_OFF = 7'h01,
        SSB_ST_RELEASE = 7'h02,
        SSB_ST_RUN = 7'h04,
        SSB_ST_DECEL = 7'h08,
        SSB_ST_ROT_WAIT = 7'h10,
        SSB_ST_STAT_HOLD = 7'h20,
        SSB_ST_DB_STOP = 7'h40
    } ssb_state_t;
endpackage
`default_nettype wire

/* File: test/ssb_checker.sv */
`default_nettype none
module ssb_checker(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_brake_engage,
    input wire logic o_motor_power,
    input wire logic o_dynamic_brake,
    input wire logic o_torque_decel,
    input wire logic o_timed_decel,
    input wire logic o_cmd_accept,
    input wire logic o_index_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
    a_rdy: assert property (p_rdy) else $error("setup without ready");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_zero; !o_pready |-> o_prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("read data outside access");
    property p_acc; o_cmd_accept |-> o_motor_power && !o_brake_engage; endproperty
    a_acc: assert property (p_acc) else $error("accept while braked");
    property p_off; $fell(o_motor_power) |-> o_brake_engage; endproperty
    a_off: assert property (p_off) else $error("power off, brake open");
    property p_dec; !(o_torque_decel && o_timed_decel); endproperty
    a_dec: assert property (p_dec) else $error("two decel modes");
    property p_db; o_dynamic_brake |-> !o_torque_decel && !o_timed_decel; endproperty
    a_db: assert property (p_db) else $error("brake during decel");
    property p_idx; $rose(o_index_pulse) |=> o_index_pulse [*8]; endproperty
    a_idx: assert property (p_idx) else $error("index pulse short");
    c_acc: cover property (o_cmd_accept);
    c_db: cover property ($rose(o_dynamic_brake));
    c_idx: cover property ($rose(o_index_pulse));
endmodule
bind ssb_sequencer ssb_checker chk_u(.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_brake_engage(o_brake_engage), .o_motor_power(o_motor_power),
    .o_dynamic_brake(o_dynamic_brake), .o_torque_decel(o_torque_decel),
    .o_timed_decel(o_timed_decel), .o_cmd_accept(o_cmd_accept), .o_index_pulse(o_index_pulse));
`default_nettype wire

/* File: test/ssb_motor.sv */
`default_nettype none
module ssb_motor(
    input wire logic i_clk,
    input wire logic i_spin,
    input wire logic i_free,
    output logic [12:0] o_speed
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_speed = 13'h0000;
    // any stop action except the rotating-disable wait bleeds speed slowly, so the stop states last a while
    always @(posedge i_clk) begin
        if (i_spin && i_free)
            o_speed <= 13'h03E8;
        else if (o_speed != 13'h0000)
            o_speed <= o_speed - 13'h0001;
    end
endmodule
`default_nettype wire

/* File: test/servo_stop_brake_sequencer_tb.sv */
`default_nettype none
module servo_stop_brake_sequencer_tb;
    import ssb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, spin = 0;
    logic en = 0, g1 = 0, g2 = 0, ot = 0, qs = 0, vib = 0, idx = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic rdy, err, er, brk, mp, db, td, tmd, acc, ip, vw, va, irq;
    logic [12:0] spd;
    int bad_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    ssb_sequencer dut_u(.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .i_enable(en), .i_fault_g1(g1), .i_fault_g2(g2), .i_overtravel(ot),
        .i_quick_stop(qs), .i_speed_rpm(spd), .i_vib_detect(vib), .i_index_event(idx),
        .o_brake_engage(brk), .o_motor_power(mp), .o_dynamic_brake(db), .o_torque_decel(td),
        .o_timed_decel(tmd), .o_cmd_accept(acc), .o_index_pulse(ip), .o_vib_warning(vw),
        .o_vib_alarm(va), .o_irq(irq));
    ssb_motor mot_u(.i_clk(clk), .i_spin(spin), .i_free(mp && !brk && !db && !td && !tmd),
        .o_speed(spd));
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wt(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge clk);
            n++;
            if (n > 50000) begin
                bad_count++;
                conclude();
            end
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        wt(rdy, 1'b1);
        rd = prd;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task t_regs;
        apb(1'b0, SSB_ADDR_VIB, 32'h0);
        chk(rd, 32'h0001_0640);
        apb(1'b1, SSB_ADDR_VIB, 32'h1);
        apb(1'b0, SSB_ADDR_VIB, 32'h0);
        chk(rd, 32'h0001_0321);
        apb(1'b1, SSB_ADDR_ADJUST, 32'h307);
        apb(1'b0, SSB_ADDR_ADJUST, 32'h0);
        chk(rd, 32'h204);
        apb(1'b1, SSB_ADDR_STOP_TORQUE, 32'h3E7);
        apb(1'b0, SSB_ADDR_STOP_TORQUE, 32'h0);
        chk(rd, 32'h15E);
        apb(1'b0, 8'h3C, 32'h0);
        chk(32'(er), 32'h1);
    endtask
    task t_vib;
        vib <= 1'b1;
        wt(vw, 1'b1);
        chk(32'(va), 32'h0);
        vib <= 1'b0;
        apb(1'b1, SSB_ADDR_VIB, 32'h2);
        vib <= 1'b1;
        wt(va, 1'b1);
        chk(32'(vw), 32'h0);
        vib <= 1'b0;
    endtask
    task t_run;
        apb(1'b1, SSB_ADDR_IRQ_MASK, 32'h8);
        en <= 1'b1;
        wt(acc, 1'b1);
        chk(32'({brk, mp}), 32'h1);
        en <= 1'b0;
        wt(mp, 1'b0);
        @(posedge clk);
        chk(32'({brk, irq}), 32'h3);
        apb(1'b1, SSB_ADDR_IRQ_STAT, 32'h8);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask
    task t_index;
        int n;
        n = 0;
        apb(1'b1, SSB_ADDR_INDEX, 32'h2);
        idx <= 1'b1;
        wt(ip, 1'b1);
        idx <= 1'b0;
        while (ip === 1'b1 && n < 50000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n > 20000 && n < 40010), 32'h1);
    endtask
    task t_fault;
        apb(1'b1, SSB_ADDR_STOP_CFG, 32'h10);
        spin <= 1'b1;
        en <= 1'b1;
        wt(acc, 1'b1);
        g2 <= 1'b1;
        wt(td, 1'b1);
        wt(db, 1'b1);
        repeat (50) @(posedge clk);
        chk(32'({db, td}), 32'h2);
        g2 <= 1'b0;
        wt(acc, 1'b1);
        apb(1'b1, SSB_ADDR_STOP_CFG, 32'h300);
        ot <= 1'b1;
        wt(tmd, 1'b1);
        repeat (20) @(posedge clk);
        chk(32'({tmd, mp, brk}), 32'h6);
        ot <= 1'b0;
        wt(acc, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk(32'({mp, db, acc, brk}), 32'h1);
        t_regs();
        t_vib();
        t_run();
        t_index();
        t_fault();
        conclude();
    end
endmodule
`default_nettype wire
